//--- design/tdc_pkg.sv
package tdc_pkg;
  // register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] OFF_CONTROL = 5'h00;
  localparam logic [4:0] OFF_FEEDBACK = 5'h04;
  localparam logic [4:0] OFF_TRACK_ERR = 5'h08;
  localparam logic [4:0] OFF_CRC = 5'h0c;
  localparam logic [4:0] OFF_ASSEMBLY = 5'h10;
  localparam logic [4:0] OFF_COMMAND = 5'h14;
  // control register write fields
  localparam int CTL_CLR_STROBE = 0;
  localparam int CTL_CLR_CRC = 1;
  localparam int CTL_LOOPBACK = 2;
  // feedback register read fields
  localparam int FB_STATUS_LSB = 0;
  localparam int FB_STROBE = 8;
  localparam int FB_WRITE_BIT = 9;
  localparam int FB_CRC_OUT = 10;
  localparam int FB_CARRY = 11;
  // data path widths
  localparam int SHIFT_W = 10;
  localparam int CRC_W = 9;
  localparam int CHAR_W = 9;
  localparam int STATUS_W = 8;
  localparam int CMD_N = 8;
  localparam int BUF_DEPTH = 2;
  // reset values
  localparam logic [7:0] CMD_N_RST = 8'hff;
  localparam logic [9:0] SHIFT_RST = 10'h000;
  localparam logic [8:0] CRC_RST = 9'h000;
  // write data multiplexer sources
  typedef enum logic [1:0] {
    TDC_WSRC_SERIAL = 2'b00,
    TDC_WSRC_CRC = 2'b01,
    TDC_WSRC_ZERO = 2'b10,
    TDC_WSRC_ONE = 2'b11
  } tdc_wsrc_t;
endpackage

//--- design/tdc_word_buffer.sv
module tdc_word_buffer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // filling side
  input wire logic in_valid,
  input wire logic [tdc_pkg::CHAR_W-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [tdc_pkg::CHAR_W-1:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [tdc_pkg::BUF_DEPTH-1:0][tdc_pkg::CHAR_W-1:0] mem;
    logic [1:0] cnt;
    logic wr_ptr;
    logic rd_ptr;
  } tdc_buf_state_t;

  tdc_buf_state_t st_r;
  tdc_buf_state_t st_nxt;
  logic push;
  logic pop;

  assign in_ready = (st_r.cnt != 2'h2);
  assign out_valid = (st_r.cnt != 2'h0);
  assign out_data = st_r.mem[st_r.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr_ptr] = in_data;
      st_nxt.wr_ptr = ~st_r.wr_ptr;
    end
    if (pop) begin
      st_nxt.rd_ptr = ~st_r.rd_ptr;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 2'h1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  buf_no_overrun_a: assert property (@(posedge sys_clk) disable iff (reset)
    st_r.cnt <= 2'h2) else $error("word buffer count beyond depth");
endmodule

//--- design/tdc_tape_data_path.sv
// Summary of operation
// [R01] drive status lines shown as feedback bits
// [R02] read strobe flag sets on read-clock fall
// [R03] only the program clears the read flag
// [R04] ten-bit track error ring loads on mark
// [R05] invert plus mark flips entering data bit
// [R06] track error ring recirculates until cleared
// [R07] write mux bit is feedback and crc input
// [R08] crc output is track zero, shifts advance
// [R09] crc checkword is nine track bits wide
// [R10] accumulate only with both crc enables
// [R11] crc input is data xor output xor carry
// [R12] carry set when exactly one input set
// [R13] ten-bit serialiser, first bit from top stage
// [R14] extra reassembly shift right-justifies bit zero
// [R15] write bit zero wraps to read path
// [R16] eight command latches picked by three bits
// [R17] set bit high sets latch, line low
// [R18] set bit low clears latch, line high
// [R19] write-load high shifts write data serially
//
// Added by the designer: the address-and-strobe port and the register offsets.
module tdc_tape_data_path (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [tdc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tdc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tdc_pkg::DATA_W-1:0] reg_rdata,
  // micro steps and subfunction decodes
  input wire logic error_mark_step,
  input wire logic bit_invert_step,
  input wire logic track_error_clear,
  input wire logic read_shift_step,
  input wire logic crc_shift_pulse,
  input wire logic crc_enable_a,
  input wire logic crc_enable_b,
  input wire logic write_load_step,
  input wire logic write_shift_step,
  input wire logic [1:0] write_source_sel,
  input wire logic command_register_decode,
  input wire logic [2:0] latch_select,
  input wire logic latch_set_clear_bit,
  // host write words
  input wire logic host_word_valid,
  input wire logic [tdc_pkg::CHAR_W-1:0] host_word_data,
  output logic host_word_ready,
  // tape drive side
  input wire logic read_clock,
  input wire logic tape_read_bit,
  input wire logic [tdc_pkg::STATUS_W-1:0] drive_status,
  output logic [tdc_pkg::CMD_N-1:0] drive_command_n,
  // feedback to the micro controller
  output logic read_strobe_feedback,
  output logic write_bit_feedback,
  output logic crc_track_output,
  output logic write_tape_bit_zero
);
  typedef struct packed {
    logic rd_clk_prev;
    logic rds_flag;
    logic [tdc_pkg::SHIFT_W-1:0] track_error_register;
    logic [tdc_pkg::SHIFT_W-1:0] asm_word;
    logic [tdc_pkg::CRC_W-1:0] crc;
    logic carry;
    logic [tdc_pkg::SHIFT_W-1:0] wsr;
    logic [tdc_pkg::CMD_N-1:0] cmd_n;
    logic loopback;
    logic [tdc_pkg::DATA_W-1:0] rdata;
  } tdc_state_t;

  tdc_state_t st_r;
  tdc_state_t st_nxt;

  logic buf_valid;
  logic [tdc_pkg::CHAR_W-1:0] buf_data;
  logic buf_take;
  logic rd_clk_fall;
  logic read_in_bit;
  logic crc_accum;
  logic crc_fb;
  logic ctl_wr;

  function automatic logic [tdc_pkg::DATA_W-1:0] zext10(
    input logic [tdc_pkg::SHIFT_W-1:0] v
  );
    zext10 = {6'h00, v};
  endfunction

  // a stalled write register backs up into the buffer and then the host
  assign buf_take = !write_load_step;

  tdc_word_buffer u_word_buffer (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(host_word_valid),
    .in_data(host_word_data),
    .in_ready(host_word_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_take)
  );

  assign rd_clk_fall = st_r.rd_clk_prev && !read_clock;
  assign ctl_wr = reg_wr && (reg_addr == tdc_pkg::OFF_CONTROL);

  // first serial bit is the top stage
  assign write_tape_bit_zero = st_r.wsr[tdc_pkg::SHIFT_W-1]; // see [R13]

  // write data multiplexer, high for a one written to tape
  always_comb begin
    unique case (tdc_pkg::tdc_wsrc_t'(write_source_sel))
      tdc_pkg::TDC_WSRC_SERIAL: write_bit_feedback = write_tape_bit_zero; // see [R07]
      tdc_pkg::TDC_WSRC_CRC: write_bit_feedback = crc_track_output;
      tdc_pkg::TDC_WSRC_ZERO: write_bit_feedback = 1'b0;
      tdc_pkg::TDC_WSRC_ONE: write_bit_feedback = 1'b1;
    endcase
  end

  assign crc_track_output = st_r.crc[tdc_pkg::CRC_W-1]; // see [R08]
  assign crc_accum = crc_enable_a && crc_enable_b; // see [R10]
  assign crc_fb = write_bit_feedback ^ crc_track_output ^ st_r.carry; // see [R11]

  // wrap source chosen before the inverter so loopback checks correction too
  assign read_in_bit = (st_r.loopback ? write_tape_bit_zero : tape_read_bit) // see [R15]
    ^ (error_mark_step && bit_invert_step); // see [R05]

  assign read_strobe_feedback = st_r.rds_flag;
  assign drive_command_n = st_r.cmd_n;
  assign reg_rdata = st_r.rdata;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_clk_prev = read_clock;

    // a fall in the clearing cycle still leaves the flag set
    if (ctl_wr && reg_wdata[tdc_pkg::CTL_CLR_STROBE]) begin
      st_nxt.rds_flag = 1'b0; // see [R03]
    end
    if (rd_clk_fall) begin
      st_nxt.rds_flag = 1'b1; // see [R02]
    end
    if (ctl_wr) begin
      st_nxt.loopback = reg_wdata[tdc_pkg::CTL_LOOPBACK];
    end

    // track error ring follows the read character one track per shift
    if (read_shift_step) begin
      st_nxt.track_error_register = {st_r.track_error_register[tdc_pkg::SHIFT_W-2:0], st_r.track_error_register[tdc_pkg::SHIFT_W-1]}; // see [R06]
    end
    if (error_mark_step) begin
      st_nxt.track_error_register[0] = 1'b1; // see [R04]
    end
    if (track_error_clear) begin
      st_nxt.track_error_register = tdc_pkg::SHIFT_RST; // see [R06]
    end

    // reassembly enters at the top; one extra shift parks bit zero at bit 0
    if (read_shift_step) begin
      st_nxt.asm_word = {read_in_bit, st_r.asm_word[tdc_pkg::SHIFT_W-1:1]}; // see [R14]
    end

    // checkword: each pulse advances one track, accumulating when enabled
    if (crc_shift_pulse) begin
      if (crc_accum) begin
        st_nxt.crc = {st_r.crc[tdc_pkg::CRC_W-2:0], crc_fb}; // see [R09]
        st_nxt.carry = write_bit_feedback ^ crc_track_output; // see [R12]
      end else begin
        st_nxt.crc = {st_r.crc[tdc_pkg::CRC_W-2:0], crc_track_output}; // see [R08]
      end
    end
    if (ctl_wr && reg_wdata[tdc_pkg::CTL_CLR_CRC]) begin
      st_nxt.crc = tdc_pkg::CRC_RST;
      st_nxt.carry = 1'b0;
    end

    // lowest order stage stays unused: character sits in the top nine
    if (write_load_step) begin
      if (write_shift_step) begin
        st_nxt.wsr = {st_r.wsr[tdc_pkg::SHIFT_W-2:0], 1'b0}; // see [R19]
      end
    end else if (buf_valid) begin
      st_nxt.wsr = {buf_data, 1'b0}; // see [R13]
    end

    if (command_register_decode) begin
      st_nxt.cmd_n[latch_select] = ~latch_set_clear_bit; // see [R16] [R17] [R18]
    end

    st_nxt.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        tdc_pkg::OFF_CONTROL: begin
          st_nxt.rdata[tdc_pkg::CTL_LOOPBACK] = st_r.loopback;
        end
        tdc_pkg::OFF_FEEDBACK: begin
          st_nxt.rdata[tdc_pkg::STATUS_W-1:0] = drive_status; // see [R01]
          st_nxt.rdata[tdc_pkg::FB_STROBE] = st_r.rds_flag;
          st_nxt.rdata[tdc_pkg::FB_WRITE_BIT] = write_bit_feedback;
          st_nxt.rdata[tdc_pkg::FB_CRC_OUT] = crc_track_output;
          st_nxt.rdata[tdc_pkg::FB_CARRY] = st_r.carry;
        end
        tdc_pkg::OFF_TRACK_ERR: st_nxt.rdata = zext10(st_r.track_error_register);
        tdc_pkg::OFF_CRC: st_nxt.rdata = {7'h00, st_r.crc};
        tdc_pkg::OFF_ASSEMBLY: st_nxt.rdata = zext10(st_r.asm_word);
        tdc_pkg::OFF_COMMAND: st_nxt.rdata = {8'h00, ~st_r.cmd_n};
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r.rd_clk_prev <= 1'b0;
      st_r.rds_flag <= 1'b0;
      st_r.track_error_register <= tdc_pkg::SHIFT_RST;
      st_r.asm_word <= tdc_pkg::SHIFT_RST;
      st_r.crc <= tdc_pkg::CRC_RST;
      st_r.carry <= 1'b0;
      st_r.wsr <= tdc_pkg::SHIFT_RST;
      st_r.cmd_n <= tdc_pkg::CMD_N_RST;
      st_r.loopback <= 1'b0;
      st_r.rdata <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  feedback_status_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R01]
    reg_rd && reg_addr == tdc_pkg::OFF_FEEDBACK
    |=> reg_rdata[7:0] == $past(drive_status))
    else $error("feedback status mismatch");

  strobe_sets_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R02]
    $past(read_clock) && !read_clock |=> read_strobe_feedback)
    else $error("read strobe flag missed fall");

  strobe_holds_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R03]
    read_strobe_feedback && !(reg_wr && reg_addr == tdc_pkg::OFF_CONTROL && reg_wdata[0])
    |=> read_strobe_feedback)
    else $error("read strobe flag lost");

  error_mark_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R04]
    error_mark_step && !track_error_clear |=> st_r.track_error_register[0])
    else $error("track error mark not loaded");

  invert_bit_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R05]
    read_shift_step && error_mark_step && bit_invert_step
    |=> st_r.asm_word[9] != ($past(st_r.loopback) ? $past(write_tape_bit_zero)
      : $past(tape_read_bit)))
    else $error("entering bit not inverted");

  tie_recirc_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R06]
    read_shift_step && !error_mark_step && !track_error_clear
    |=> st_r.track_error_register == {$past(st_r.track_error_register[8:0]), $past(st_r.track_error_register[9])})
    else $error("track error ring not recirculating");

  tie_clear_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R06]
    track_error_clear |=> st_r.track_error_register == 10'h000)
    else $error("track error ring not cleared");

  crc_feed_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R11]
    crc_shift_pulse && crc_accum && !ctl_wr
    |=> st_r.crc[0] == ($past(write_bit_feedback) ^ $past(crc_track_output)
      ^ $past(st_r.carry)))
    else $error("crc feedback wrong");

  crc_carry_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R12]
    crc_shift_pulse && crc_accum && !ctl_wr
    |=> st_r.carry == ($past(write_bit_feedback) != $past(crc_track_output)))
    else $error("crc carry wrong");

  crc_idle_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R10]
    !crc_accum && !ctl_wr |=> st_r.carry == $past(st_r.carry))
    else $error("carry moved without enables");

  crc_advance_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R08]
    crc_shift_pulse && !ctl_wr |=> crc_track_output == $past(st_r.crc[7]))
    else $error("crc output did not advance");

  write_shift_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R19]
    write_load_step && write_shift_step
    |=> write_tape_bit_zero == $past(st_r.wsr[8]) && st_r.wsr[0] == 1'b0)
    else $error("write data not shifted");

  write_load_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R13]
    !write_load_step && buf_valid |=> st_r.wsr == {$past(buf_data), 1'b0})
    else $error("write word not loaded high");

  loopback_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R15]
    read_shift_step && st_r.loopback && !error_mark_step
    |=> st_r.asm_word[9] == $past(write_tape_bit_zero))
    else $error("write bit zero not wrapped");

  cmd_set_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R17]
    command_register_decode && latch_set_clear_bit
    |=> !drive_command_n[$past(latch_select)])
    else $error("command latch not set");

  cmd_clear_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R18]
    command_register_decode && !latch_set_clear_bit
    |=> drive_command_n[$past(latch_select)])
    else $error("command latch not cleared");

  cmd_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R16]
    !command_register_decode |=> $stable(drive_command_n))
    else $error("command latches changed unaddressed");

  strobe_clear_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R03]
    ctl_wr && reg_wdata[tdc_pkg::CTL_CLR_STROBE] && !rd_clk_fall
    |=> !read_strobe_feedback)
    else $error("read strobe flag not cleared");

  strobe_quiet_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R02]
    !read_strobe_feedback && !rd_clk_fall |=> !read_strobe_feedback)
    else $error("read strobe flag set without a fall");

  tie_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R06]
    !read_shift_step && !error_mark_step && !track_error_clear |=> $stable(st_r.track_error_register))
    else $error("track error ring moved while idle");

  asm_shift_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R14]
    read_shift_step |=> st_r.asm_word[8:0] == $past(st_r.asm_word[9:1]))
    else $error("reassembly register not shifted");

  wbit_mux_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R07]
    write_bit_feedback == (write_source_sel == 2'h0 ? write_tape_bit_zero
      : write_source_sel == 2'h1 ? crc_track_output : write_source_sel[0]))
    else $error("write multiplexer output wrong");

  crc_rotate_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R10]
    crc_shift_pulse && !crc_accum && !ctl_wr
    |=> st_r.crc == {$past(st_r.crc[7:0]), $past(st_r.crc[8])})
    else $error("crc accumulated without both enables");

  crc_clear_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R09]
    ctl_wr && reg_wdata[tdc_pkg::CTL_CLR_CRC]
    |=> st_r.crc == tdc_pkg::CRC_RST && !st_r.carry)
    else $error("crc checkword not cleared");

  wsr_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R19]
    write_load_step && !write_shift_step |=> $stable(st_r.wsr))
    else $error("write register moved while stalled");
endmodule

//--- test/tdc_drive_model.sv
module tdc_drive_model #(
  parameter logic [7:0] STATUS = 8'ha5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // bench requests one character
  input wire logic char_req,
  input wire logic char_bit,
  // drive interface
  input wire logic [7:0] drive_command_n,
  output logic read_clock,
  output logic tape_read_bit,
  output logic [7:0] drive_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r;
  logic tog_r;
  always @(posedge sys_clk) begin
    tog_r <= reset ? 1'b0 : !tog_r;
    if (reset)
      ph_r <= 2'h0;
    else if (char_req)
      ph_r <= 2'h2;
    else if (ph_r != 2'h0)
      ph_r <= ph_r - 2'h1;
  end
  // clock stands low between characters, data line is junk outside a frame
  assign read_clock = (ph_r != 2'h0);
  assign tape_read_bit = read_clock ? char_bit : tog_r;
  // unselected drive releases its lines, pull-ups read all ones
  assign drive_status = drive_command_n[0] ? 8'hff : STATUS;
endmodule

//--- test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
  int mismatches = 0;
  int comparisons = 0;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic error_mark_step = 1'b0, bit_invert_step = 1'b0, track_error_clear = 1'b0;
  logic read_shift_step = 1'b0, crc_shift_pulse = 1'b0, crc_enable_a = 1'b0;
  logic crc_enable_b = 1'b0, write_load_step = 1'b1, write_shift_step = 1'b0;
  logic [1:0] write_source_sel = 2'h2;
  logic command_register_decode = 1'b0, latch_set_clear_bit = 1'b0;
  logic [2:0] latch_select = 3'h0;
  logic host_word_valid = 1'b0, host_word_ready;
  logic [8:0] host_word_data = 9'h000, crc, e9;
  logic read_clock, tape_read_bit, char_req = 1'b0;
  logic [7:0] drive_status, drive_command_n, cmd;
  logic read_strobe_feedback, write_bit_feedback, crc_track_output, write_tape_bit_zero;
  logic carry;
  logic [9:0] asm_e;
  always #10 sys_clk = !sys_clk;
  tdc_tape_data_path dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .error_mark_step, .bit_invert_step, .track_error_clear, .read_shift_step,
    .crc_shift_pulse, .crc_enable_a, .crc_enable_b, .write_load_step, .write_shift_step,
    .write_source_sel, .command_register_decode, .latch_select, .latch_set_clear_bit,
    .host_word_valid, .host_word_data, .host_word_ready, .read_clock, .tape_read_bit,
    .drive_status, .drive_command_n, .read_strobe_feedback, .write_bit_feedback,
    .crc_track_output, .write_tape_bit_zero);
  tdc_drive_model drv (.sys_clk, .reset, .char_req, .char_bit(1'b1), .drive_command_n,
    .read_clock, .tape_read_bit, .drive_status);
  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // a gap edge after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    clk(1);
    reg_wr <= 1'b0;
    clk(1);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    clk(1);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
    clk(1);
  endtask
  task automatic latch(input logic [2:0] i, input logic s);
    command_register_decode <= 1'b1;
    latch_select <= i;
    latch_set_clear_bit <= s;
    clk(1);
    command_register_decode <= 1'b0;
    clk(1);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk(4);
    reset <= 1'b0;
    clk(1);
    `CHK("cmd_rst", 8'hff, drive_command_n)
    rd(5'h18, 16'h0000);
    rd(tdc_pkg::OFF_FEEDBACK, 16'h00ff);
    cmd = 8'hff;
    for (int i = 0; i < 8; i++) begin
      latch(i[2:0], 1'b1);
      cmd[i] = 1'b0;
      `CHK("cmd_set", cmd, drive_command_n)
    end
    latch(3'h3, 1'b0);
    `CHK("cmd_clr", 8'h08, drive_command_n)
    rd(tdc_pkg::OFF_COMMAND, 16'h00f7);
    rd(tdc_pkg::OFF_FEEDBACK, 16'h00a5);
    // read strobe flag
    char_req <= 1'b1;
    clk(1);
    char_req <= 1'b0;
    for (int n = 0; n < 10 && read_strobe_feedback !== 1'b1; n++)
      clk(1);
    `CHK("strobe_set", 1'b1, read_strobe_feedback)
    if (read_strobe_feedback !== 1'b1)
      results();
    clk(5);
    rd(tdc_pkg::OFF_FEEDBACK, 16'h01a5);
    wr(tdc_pkg::OFF_CONTROL, 16'h0001);
    `CHK("strobe_clr", 1'b0, read_strobe_feedback)
    // crc accumulation with a constant one bit
    write_source_sel <= 2'h3;
    wr(tdc_pkg::OFF_CONTROL, 16'h0002);
    `CHK("wbit", 1'b1, write_bit_feedback)
    crc = 9'h000;
    carry = 1'b0;
    crc_enable_a <= 1'b1;
    crc_enable_b <= 1'b1;
    crc_shift_pulse <= 1'b1;
    // new carry is the half sum of data and output, both taken before the shift
    repeat (12) begin
      clk(1);
      {crc, carry} = {crc[7:0], 1'b1 ^ crc[8] ^ carry, 1'b1 ^ crc[8]};
    end
    crc_shift_pulse <= 1'b0;
    clk(1);
    rd(tdc_pkg::OFF_CRC, {7'h00, crc});
    rd(tdc_pkg::OFF_FEEDBACK, {4'h0, carry, crc[8], 2'b10, 8'ha5});
    `CHK("crc_out", crc[8], crc_track_output)
    crc_enable_b <= 1'b0;
    crc_shift_pulse <= 1'b1;
    clk(3);
    crc_shift_pulse <= 1'b0;
    clk(1);
    crc = {crc[5:0], crc[8:6]};
    rd(tdc_pkg::OFF_CRC, {7'h00, crc});
    rd(tdc_pkg::OFF_FEEDBACK, {4'h0, carry, crc[8], 2'b10, 8'ha5});
    write_source_sel <= 2'h1;
    clk(1);
    `CHK("wbit_crc", crc[8], write_bit_feedback)
    wr(tdc_pkg::OFF_CONTROL, 16'h0002);
    rd(tdc_pkg::OFF_CRC, 16'h0000);
    rd(tdc_pkg::OFF_FEEDBACK, 16'h00a5);
    // track error ring
    error_mark_step <= 1'b1;
    clk(1);
    error_mark_step <= 1'b0;
    clk(1);
    rd(tdc_pkg::OFF_TRACK_ERR, 16'h0001);
    read_shift_step <= 1'b1;
    clk(10);
    read_shift_step <= 1'b0;
    clk(1);
    rd(tdc_pkg::OFF_TRACK_ERR, 16'h0001);
    track_error_clear <= 1'b1;
    clk(1);
    track_error_clear <= 1'b0;
    clk(1);
    rd(tdc_pkg::OFF_TRACK_ERR, 16'h0000);
    // fill the buffer while the write register stalls
    host_word_valid <= 1'b1;
    host_word_data <= 9'h1a3;
    clk(1);
    host_word_data <= 9'h05c;
    clk(1);
    host_word_data <= 9'h0ff;
    #1;
    `CHK("full", 1'b0, host_word_ready)
    clk(1);
    host_word_valid <= 1'b0;
    write_load_step <= 1'b0;
    clk(1);
    write_load_step <= 1'b1;
    clk(1);
    `CHK("first_bit", 1'b1, write_tape_bit_zero)
    // loop the word back through the read path, first bit inverted
    wr(tdc_pkg::OFF_CONTROL, 16'h0004);
    rd(tdc_pkg::OFF_CONTROL, 16'h0004);
    write_shift_step <= 1'b1;
    read_shift_step <= 1'b1;
    error_mark_step <= 1'b1;
    bit_invert_step <= 1'b1;
    clk(1);
    error_mark_step <= 1'b0;
    bit_invert_step <= 1'b0;
    clk(9);
    write_shift_step <= 1'b0;
    read_shift_step <= 1'b0;
    clk(1);
    e9 = 9'h1a3;
    asm_e = 10'h000;
    for (int k = 0; k < 9; k++)
      asm_e[k] = e9[8-k];
    asm_e[0] = !asm_e[0];
    rd(tdc_pkg::OFF_ASSEMBLY, {6'h00, asm_e});
    write_source_sel <= 2'h0;
    write_load_step <= 1'b0;
    clk(1);
    write_load_step <= 1'b1;
    clk(1);
    `CHK("second_bit", 1'b0, write_tape_bit_zero)
    `CHK("drained", 1'b1, host_word_ready)
    // two shifts bring the third character bit of 9'h05c to the top
    write_shift_step <= 1'b1;
    clk(2);
    write_shift_step <= 1'b0;
    clk(1);
    `CHK("third_bit", 1'b1, write_tape_bit_zero)
    `CHK("wbit_serial", 1'b1, write_bit_feedback)
    results();
  end
endmodule
